/* File: verilog/vsc_defs.svh */
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH
`define VSC_AW            9
`define VSC_DW            12
`define VSC_ADDR_MODE     9'h040
`define VSC_ADDR_YOFFS    9'h041
`define VSC_ADDR_LEN      9'h042
`define VSC_ADDR_CINC     9'h043
`define VSC_ADDR_EINC     9'h044
`define VSC_ADDR_NLCOEF   9'h045
`define VSC_ADDR_W1_BASE  9'h047
`define VSC_ADDR_W2_BASE  9'h04C
`define VSC_ADDR_IRQ_STAT 9'h060
`define VSC_ADDR_IRQ_MASK 9'h061
`define VSC_WIN_CNT       5
`define VSC_WIN_TOTAL     10
`define VSC_RST_MODE      12'h000
`define VSC_RST_YOFFS     7'h39
`define VSC_RST_LEN       12'h438
`define VSC_RST_INC       12'h400
`define VSC_RST_ZERO      12'h000
`define VSC_MODE_LSB      0
`define VSC_MODE_MSB      1
`define VSC_UPD_BIT       11
`define VSC_YOFFS_MSB     6
`define VSC_IRQ_W         2
`define VSC_IRQ_UPD       0
`define VSC_IRQ_RSVD      1
`endif

/* File: verilog/vsc_pkg.sv */
package vsc_pkg;
  typedef enum logic [1:0] {
    VSC_LINEAR,
    VSC_PANORAMA,
    VSC_WATERGLASS,
    VSC_RESERVED
  } vsc_mode_t;
  typedef logic [11:0] vsc_word_t;
  typedef enum logic [0:0] {
    VSC_IDLE,
    VSC_COPY
  } vsc_state_t;
endpackage : vsc_pkg

/* File: verilog/vsc_win_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vsc_defs.svh"
module vsc_win_mem (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                wr_en_i,
  input  wire logic [3:0]          wr_idx_i,
  input  wire vsc_pkg::vsc_word_t  wr_data_i,
  input  wire logic [3:0]          rd_idx_i,
  output vsc_pkg::vsc_word_t       rd_data_o,
  output vsc_pkg::vsc_word_t       win_flat_o [`VSC_WIN_TOTAL]
);
  import vsc_pkg::*;
  typedef struct packed {
    vsc_word_t [`VSC_WIN_TOTAL-1:0] mem;
    vsc_word_t                      rd;
  } vsc_mem_st_t;
  vsc_mem_st_t st_q;
  vsc_mem_st_t st_d;
  always_comb begin
    st_d = st_q;
    if (wr_en_i && (wr_idx_i < 4'(`VSC_WIN_TOTAL))) begin
      st_d.mem[wr_idx_i] = wr_data_i;
    end
    st_d.rd = (rd_idx_i < 4'(`VSC_WIN_TOTAL)) ? st_q.mem[rd_idx_i] : `VSC_RST_ZERO;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign rd_data_o = st_q.rd;
  for (genvar g = 0; g < `VSC_WIN_TOTAL; g++) begin : g_flat
    assign win_flat_o[g] = st_q.mem[g];
  end
endmodule : vsc_win_mem
`default_nettype wire

/* File: verilog/vsc_regs.sv */
// Notes on behaviour
// RQ1 - mode field: linear, panorama, waterglass, reserved
// RQ2 - software writes zero to reserved bits
// RQ3 - update bit cleared by write, set when done
// RQ4 - staged values apply only on mode write
// RQ5 - seven-bit luma offset, default 57
// RQ6 - twelve-bit line length, default 1080
// RQ7 - compress increment c*1024, default 1024
// RQ8 - expand increment 1024/c, default 1024
// RQ9 - shared nonlinear coefficient, resets zero
// RQ10 - five window registers per scaler, zero
// RQ11 - linear mode needs only few registers
// RQ12 - all staged values copied together
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "vsc_defs.svh"
module vsc_regs (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [`VSC_AW-1:0]    addr_i,
  input  wire vsc_pkg::vsc_word_t    wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output vsc_pkg::vsc_word_t         rdata_o,
  output vsc_pkg::vsc_mode_t         act_mode_o,
  output logic [`VSC_YOFFS_MSB:0]    act_yoffs_o,
  output vsc_pkg::vsc_word_t         act_len_o,
  output vsc_pkg::vsc_word_t         act_cinc_o,
  output vsc_pkg::vsc_word_t         act_einc_o,
  output vsc_pkg::vsc_word_t         act_nlcoef_o,
  output vsc_pkg::vsc_word_t         act_win_o [`VSC_WIN_TOTAL],
  output logic                       mode_nonlinear_o,
  output logic                       irq_o
);
  import vsc_pkg::*;

  typedef struct packed {
    vsc_word_t                      mode;
    logic [`VSC_YOFFS_MSB:0]        yoffs;
    vsc_word_t                      len;
    vsc_word_t                      cinc;
    vsc_word_t                      einc;
    vsc_word_t                      nlcoef;
    vsc_mode_t                      a_mode;
    logic [`VSC_YOFFS_MSB:0]        a_yoffs;
    vsc_word_t                      a_len;
    vsc_word_t                      a_cinc;
    vsc_word_t                      a_einc;
    vsc_word_t                      a_nlcoef;
    vsc_word_t [`VSC_WIN_TOTAL-1:0] a_win;
    vsc_state_t                     state;
    logic [`VSC_IRQ_W-1:0]          stat;
    logic [`VSC_IRQ_W-1:0]          mask;
    vsc_word_t                      rdata;
    logic                           rd_win;
  } vsc_st_t;

  vsc_st_t   st_q;
  vsc_st_t   st_d;
  logic      win_hit;
  logic [3:0] win_idx;
  vsc_word_t win_rd;
  vsc_word_t win_stage [`VSC_WIN_TOTAL];

  always_comb begin
    win_hit = 1'b0;
    win_idx = 4'h0;
    if (addr_i >= `VSC_ADDR_W1_BASE && addr_i < `VSC_ADDR_W1_BASE + 9'(`VSC_WIN_TOTAL)) begin
      win_hit = 1'b1;
      win_idx = 4'(addr_i - `VSC_ADDR_W1_BASE);
    end
  end

  // RQ10 window staging
  vsc_win_mem u_win (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .wr_en_i    (wr_i && win_hit),
    .wr_idx_i   (win_idx),
    .wr_data_i  (wdata_i),
    .rd_idx_i   (win_idx),
    .rd_data_o  (win_rd),
    .win_flat_o (win_stage)
  );

  always_comb begin
    st_d = st_q;
    st_d.rd_win = rd_i && win_hit;
    st_d.rdata = `VSC_RST_ZERO;
    // RQ12 one-shot copy
    if (st_q.state == VSC_COPY) begin
      st_d.a_mode   = vsc_mode_t'(st_q.mode[`VSC_MODE_MSB:`VSC_MODE_LSB]);
      st_d.a_yoffs  = st_q.yoffs;
      st_d.a_len    = st_q.len;
      st_d.a_cinc   = st_q.cinc;
      st_d.a_einc   = st_q.einc;
      st_d.a_nlcoef = st_q.nlcoef;
      for (int i = 0; i < `VSC_WIN_TOTAL; i++) begin
        st_d.a_win[i] = win_stage[i];
      end
      // RQ3 done sets bit
      st_d.mode[`VSC_UPD_BIT] = 1'b1;
      st_d.stat[`VSC_IRQ_UPD] = 1'b1;
      st_d.state = VSC_IDLE;
    end
    if (wr_i) begin
      if (addr_i == `VSC_ADDR_MODE) begin
        // RQ4 mode write starts transfer
        st_d.mode = wdata_i;
        st_d.mode[`VSC_UPD_BIT] = 1'b0;
        st_d.state = VSC_COPY;
        // RQ2 flag reserved-bit misuse
        if (wdata_i[`VSC_UPD_BIT-1:`VSC_MODE_MSB+1] != '0) begin
          st_d.stat[`VSC_IRQ_RSVD] = 1'b1;
        end
      end else if (addr_i == `VSC_ADDR_YOFFS) begin
        // RQ5 seven-bit offset
        st_d.yoffs = wdata_i[`VSC_YOFFS_MSB:0];
      end else if (addr_i == `VSC_ADDR_LEN) begin
        // RQ6 line length
        st_d.len = wdata_i;
      end else if (addr_i == `VSC_ADDR_CINC) begin
        // RQ7 compress increment
        st_d.cinc = wdata_i;
      end else if (addr_i == `VSC_ADDR_EINC) begin
        // RQ8 expand increment
        st_d.einc = wdata_i;
      end else if (addr_i == `VSC_ADDR_NLCOEF) begin
        // RQ9 nonlinear coefficient
        st_d.nlcoef = wdata_i;
      end else if (addr_i == `VSC_ADDR_IRQ_STAT) begin
        st_d.stat = st_q.stat & ~wdata_i[`VSC_IRQ_W-1:0];
        if (st_q.state == VSC_COPY) begin
          st_d.stat[`VSC_IRQ_UPD] = 1'b1;
        end
      end else if (addr_i == `VSC_ADDR_IRQ_MASK) begin
        st_d.mask = wdata_i[`VSC_IRQ_W-1:0];
      end
    end
    if (rd_i) begin
      if (addr_i == `VSC_ADDR_MODE) begin
        st_d.rdata = st_q.mode;
      end else if (addr_i == `VSC_ADDR_YOFFS) begin
        st_d.rdata = {5'h0, st_q.yoffs};
      end else if (addr_i == `VSC_ADDR_LEN) begin
        st_d.rdata = st_q.len;
      end else if (addr_i == `VSC_ADDR_CINC) begin
        st_d.rdata = st_q.cinc;
      end else if (addr_i == `VSC_ADDR_EINC) begin
        st_d.rdata = st_q.einc;
      end else if (addr_i == `VSC_ADDR_NLCOEF) begin
        st_d.rdata = st_q.nlcoef;
      end else if (addr_i == `VSC_ADDR_IRQ_STAT) begin
        st_d.rdata = {10'h0, st_q.stat};
      end else if (addr_i == `VSC_ADDR_IRQ_MASK) begin
        st_d.rdata = {10'h0, st_q.mask};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q          <= '0;
      st_q.mode     <= `VSC_RST_MODE;
      st_q.yoffs    <= `VSC_RST_YOFFS;
      st_q.len      <= `VSC_RST_LEN;
      st_q.cinc     <= `VSC_RST_INC;
      st_q.einc     <= `VSC_RST_INC;
      st_q.nlcoef   <= `VSC_RST_ZERO;
      st_q.a_mode   <= VSC_LINEAR;
      st_q.a_yoffs  <= `VSC_RST_YOFFS;
      st_q.a_len    <= `VSC_RST_LEN;
      st_q.a_cinc   <= `VSC_RST_INC;
      st_q.a_einc   <= `VSC_RST_INC;
      st_q.a_nlcoef <= `VSC_RST_ZERO;
      st_q.state    <= VSC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o      = st_q.rd_win ? win_rd : st_q.rdata;
  assign act_mode_o   = st_q.a_mode;
  assign act_yoffs_o  = st_q.a_yoffs;
  assign act_len_o    = st_q.a_len;
  assign act_cinc_o   = st_q.a_cinc;
  assign act_einc_o   = st_q.a_einc;
  assign act_nlcoef_o = st_q.a_nlcoef;
  for (genvar g = 0; g < `VSC_WIN_TOTAL; g++) begin : g_act
    assign act_win_o[g] = st_q.a_win[g];
  end

  // RQ1 mode decode
  always_comb begin
    case (st_q.a_mode)
      VSC_PANORAMA:   mode_nonlinear_o = 1'b1;
      VSC_WATERGLASS: mode_nonlinear_o = 1'b1;
      default:        mode_nonlinear_o = 1'b0;
    endcase
  end

  assign irq_o = |(st_q.stat & st_q.mask);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // RQ4 mode write copies
  chk_mode_write_copy: assert property (wr_i && addr_i == `VSC_ADDR_MODE ##1 !wr_i // RQ4
    |=> act_mode_o == vsc_mode_t'($past(wdata_i[`VSC_MODE_MSB:`VSC_MODE_LSB], 2)))
    else $error("active mode not taken from mode write");
  // RQ3 write clears bit
  chk_upd_clear: assert property (wr_i && addr_i == `VSC_ADDR_MODE |=> !st_q.mode[`VSC_UPD_BIT]) // RQ3
    else $error("update bit not cleared by mode write");
  // RQ3 copy sets bit
  chk_upd_set: assert property (wr_i && addr_i == `VSC_ADDR_MODE ##1 !wr_i |=> st_q.mode[`VSC_UPD_BIT]) // RQ3
    else $error("update bit not set after copy");
  // RQ4 length held otherwise
  chk_len_staged: assert property (!(st_q.state == VSC_COPY) |=> $stable(act_len_o)) // RQ4
    else $error("active length changed without mode write");
  // RQ12 single copy point
  chk_atomic_copy: assert property ($changed(act_cinc_o) || $changed(act_win_o[0]) // RQ12
    |-> $past(st_q.state) == VSC_COPY)
    else $error("active set changed outside copy");
  // RQ5 offset staged
  chk_yoffs_range: assert property (wr_i && addr_i == `VSC_ADDR_YOFFS // RQ5
    |=> st_q.yoffs == $past(wdata_i[`VSC_YOFFS_MSB:0]))
    else $error("luma offset not stored");
  // RQ1 nonlinear decode
  chk_nl_decode: assert property ( // RQ1
    mode_nonlinear_o == (act_mode_o == VSC_PANORAMA || act_mode_o == VSC_WATERGLASS))
    else $error("nonlinear decode wrong");
  // RQ10 second bank index
  chk_win_idx: assert property (wr_i && addr_i == `VSC_ADDR_W2_BASE // RQ10
    |-> win_hit && win_idx == 4'(`VSC_WIN_CNT))
    else $error("second window bank index wrong");
  // interrupt from status and mask
  chk_irq_level: assert property (irq_o == |(st_q.stat & st_q.mask))
    else $error("interrupt level wrong");
  // RQ3 set beats clear
  chk_set_wins: assert property (st_q.state == VSC_COPY |=> st_q.stat[`VSC_IRQ_UPD]) // RQ3
    else $error("update status not set by copy");
  // RQ12 copy lasts one cycle
  chk_copy_done: assert property (st_q.state == VSC_COPY && !(wr_i && addr_i == `VSC_ADDR_MODE) // RQ12
    |=> st_q.state == VSC_IDLE)
    else $error("copy state did not end");
  // RQ1 mode copied
  chk_copy_mode: assert property (st_q.state == VSC_COPY // RQ1
    |=> act_mode_o == vsc_mode_t'($past(st_q.mode[`VSC_MODE_MSB:`VSC_MODE_LSB])))
    else $error("active mode not copied");
  // RQ5 offset copied
  chk_copy_yoffs: assert property (st_q.state == VSC_COPY |=> act_yoffs_o == $past(st_q.yoffs)) // RQ5
    else $error("active luma offset not copied");
  // RQ6 length copied
  chk_copy_len: assert property (st_q.state == VSC_COPY |=> act_len_o == $past(st_q.len)) // RQ6
    else $error("active length not copied");
  // RQ4 compress increment copied
  chk_copy_cinc: assert property (st_q.state == VSC_COPY |=> act_cinc_o == $past(st_q.cinc)) // RQ4
    else $error("active compress increment not copied");
  // RQ4 expand increment copied
  chk_copy_einc: assert property (st_q.state == VSC_COPY |=> act_einc_o == $past(st_q.einc)) // RQ4
    else $error("active expand increment not copied");
  // RQ9 coefficient copied
  chk_copy_coef: assert property (st_q.state == VSC_COPY |=> act_nlcoef_o == $past(st_q.nlcoef)) // RQ9
    else $error("active coefficient not copied");
  // RQ10 last window of first bank copied
  chk_copy_win_a: assert property (st_q.state == VSC_COPY // RQ10
    |=> act_win_o[`VSC_WIN_CNT-1] == $past(win_stage[`VSC_WIN_CNT-1]))
    else $error("first bank window not copied");
  // RQ10 last window of second bank copied
  chk_copy_win_b: assert property (st_q.state == VSC_COPY // RQ10
    |=> act_win_o[`VSC_WIN_TOTAL-1] == $past(win_stage[`VSC_WIN_TOTAL-1]))
    else $error("second bank window not copied");
  // RQ1 mode field stored
  chk_mode_field: assert property (wr_i && addr_i == `VSC_ADDR_MODE // RQ1
    |=> st_q.mode[`VSC_MODE_MSB:`VSC_MODE_LSB] == $past(wdata_i[`VSC_MODE_MSB:`VSC_MODE_LSB]))
    else $error("mode field not stored");
  // RQ2 reserved bits flagged
  chk_rsvd_flag: assert property (wr_i && addr_i == `VSC_ADDR_MODE // RQ2
    && wdata_i[`VSC_UPD_BIT-1:`VSC_MODE_MSB+1] != '0 |=> st_q.stat[`VSC_IRQ_RSVD])
    else $error("reserved bit write not flagged");
  // RQ3 bit held otherwise
  chk_upd_hold: assert property (!(wr_i && addr_i == `VSC_ADDR_MODE) && st_q.state != VSC_COPY // RQ3
    |=> $stable(st_q.mode[`VSC_UPD_BIT]))
    else $error("update bit changed without cause");
  // RQ4 offset held otherwise
  chk_yoffs_stable: assert property (st_q.state != VSC_COPY |=> $stable(act_yoffs_o)) // RQ4
    else $error("active offset changed without mode write");
  // RQ4 mode held otherwise
  chk_mode_hold: assert property (st_q.state != VSC_COPY |=> $stable(act_mode_o)) // RQ4
    else $error("active mode changed without mode write");
  // RQ4 first window of second bank held otherwise
  chk_win_stable: assert property (st_q.state != VSC_COPY |=> $stable(act_win_o[`VSC_WIN_CNT])) // RQ4
    else $error("active window changed without mode write");
  // RQ3 mode read back
  chk_mode_read: assert property (rd_i && addr_i == `VSC_ADDR_MODE |=> rdata_o == $past(st_q.mode)) // RQ3
    else $error("mode read data wrong");
  // RQ10 window read back
  chk_win_read: assert property (rd_i && win_hit |=> rdata_o == $past(win_stage[win_idx])) // RQ10
    else $error("window read data wrong");
  // read data only after strobe
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == `VSC_RST_ZERO)
    else $error("read data not zero without read");

  cov_mode_write: cover property (wr_i && addr_i == `VSC_ADDR_MODE ##2 st_q.mode[`VSC_UPD_BIT]);
  cov_panorama: cover property (act_mode_o == VSC_PANORAMA);
  cov_irq: cover property (irq_o);
  cov_waterglass: cover property (act_mode_o == VSC_WATERGLASS);
  cov_set_wins: cover property (st_q.state == VSC_COPY && wr_i && addr_i == `VSC_ADDR_IRQ_STAT);
endmodule : vsc_regs
`default_nettype wire

/* File: verification/tb_video_scaler_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vsc_defs.svh"
module tb_video_scaler_control_regs;
  import vsc_pkg::*;
  logic                 ref_clk_i;
  logic                 rst_b_i;
  logic [`VSC_AW-1:0]   addr_i;
  vsc_word_t            wdata_i;
  logic                 wr_i;
  logic                 rd_i;
  vsc_word_t            rdata_o;
  vsc_mode_t            act_mode_o;
  logic [6:0]           act_yoffs_o;
  vsc_word_t            act_len_o;
  vsc_word_t            act_cinc_o;
  vsc_word_t            act_einc_o;
  vsc_word_t            act_nlcoef_o;
  vsc_word_t            act_win_o [`VSC_WIN_TOTAL];
  logic                 mode_nonlinear_o;
  logic                 irq_o;
  int                   err_total;
  int                   samples_checked;
  int                   cyc;
  vsc_regs i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .act_mode_o(act_mode_o), .act_yoffs_o(act_yoffs_o), .act_len_o(act_len_o),
    .act_cinc_o(act_cinc_o), .act_einc_o(act_einc_o), .act_nlcoef_o(act_nlcoef_o), .act_win_o(act_win_o),
    .mode_nonlinear_o(mode_nonlinear_o), .irq_o(irq_o));
  always #12.5 ref_clk_i = ~ref_clk_i;
  task automatic results();
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input string nm, input vsc_word_t exp, input vsc_word_t got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [`VSC_AW-1:0] a, input vsc_word_t d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string nm, input logic [`VSC_AW-1:0] a, input vsc_word_t exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(nm, exp, rdata_o);
  endtask : rd_chk
  task automatic chk_active(input vsc_word_t yo, ln, ci, ei, nc, wb);
    chk("act_yoffs", yo, vsc_word_t'(act_yoffs_o));
    chk("act_len", ln, act_len_o);
    chk("act_cinc", ci, act_cinc_o);
    chk("act_einc", ei, act_einc_o);
    chk("act_nlcoef", nc, act_nlcoef_o);
    for (int i = 0; i < `VSC_WIN_TOTAL; i++) chk("act_win", (wb == 12'h000) ? wb : wb + vsc_word_t'(i), act_win_o[i]);
  endtask : chk_active
  task automatic test_reset_values();
    chk_active(12'h039, 12'h438, 12'h400, 12'h400, 12'h000, 12'h000);
    rd_chk("mode", `VSC_ADDR_MODE, 12'h000);
    rd_chk("yoffs", `VSC_ADDR_YOFFS, 12'h039);
    rd_chk("len", `VSC_ADDR_LEN, 12'h438);
    rd_chk("cinc", `VSC_ADDR_CINC, 12'h400);
    rd_chk("einc", `VSC_ADDR_EINC, 12'h400);
    rd_chk("nlcoef", `VSC_ADDR_NLCOEF, 12'h000);
    rd_chk("unmapped", 9'h046, 12'h000);
    for (int i = 0; i < `VSC_WIN_TOTAL; i++) rd_chk("win", `VSC_ADDR_W1_BASE + 9'(i), 12'h000);
  endtask : test_reset_values
  task automatic test_staged_update();
    wr(`VSC_ADDR_YOFFS, 12'h07F);
    wr(`VSC_ADDR_LEN, 12'h3B1);
    wr(`VSC_ADDR_CINC, 12'hFFF);
    wr(`VSC_ADDR_EINC, 12'h100);
    wr(`VSC_ADDR_NLCOEF, 12'h05A);
    for (int i = 0; i < `VSC_WIN_TOTAL; i++) wr(`VSC_ADDR_W1_BASE + 9'(i), 12'h100 + vsc_word_t'(i));
    rd_chk("stg_yoffs", `VSC_ADDR_YOFFS, 12'h07F);
    rd_chk("stg_win9", `VSC_ADDR_W2_BASE + 9'h004, 12'h109);
    chk_active(12'h039, 12'h438, 12'h400, 12'h400, 12'h000, 12'h000);
    wr(`VSC_ADDR_MODE, 12'h802);
    addr_i <= `VSC_ADDR_MODE;
    rd_i   <= 1'b1;
    #1;
    chk_active(12'h039, 12'h438, 12'h400, 12'h400, 12'h000, 12'h000);
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk("mode_busy", 12'h002, rdata_o);
    chk_active(12'h07F, 12'h3B1, 12'hFFF, 12'h100, 12'h05A, 12'h100);
    rd_chk("mode_done", `VSC_ADDR_MODE, 12'h802);
    chk("irq_masked", 12'h000, vsc_word_t'(irq_o));
  endtask : test_staged_update
  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      wr(`VSC_ADDR_MODE, vsc_word_t'(m));
      @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      #1;
      chk("act_mode", vsc_word_t'(m), vsc_word_t'(act_mode_o));
      chk("nonlinear", vsc_word_t'(m == 1 || m == 2), vsc_word_t'(mode_nonlinear_o));
    end
  endtask : test_modes
  task automatic test_irq();
    rd_chk("irq_stat", `VSC_ADDR_IRQ_STAT, 12'h001);
    wr(`VSC_ADDR_IRQ_MASK, 12'h001);
    @(posedge ref_clk_i);
    #1;
    chk("irq_on", 12'h001, vsc_word_t'(irq_o));
    wr(`VSC_ADDR_IRQ_STAT, 12'h001);
    @(posedge ref_clk_i);
    #1;
    chk("irq_clr", 12'h000, vsc_word_t'(irq_o));
    wr(`VSC_ADDR_MODE, 12'h004);
    rd_chk("irq_rsvd", `VSC_ADDR_IRQ_STAT, 12'h003);
    rd_chk("mode_rsvd", `VSC_ADDR_MODE, 12'h804);
    rd_chk("irq_mask", `VSC_ADDR_IRQ_MASK, 12'h001);
    chk("irq_lvl", 12'h001, vsc_word_t'(irq_o));
  endtask : test_irq
  task automatic test_linear();
    wr(`VSC_ADDR_LEN, 12'h3D9);
    wr(`VSC_ADDR_CINC, 12'h400);
    wr(`VSC_ADDR_EINC, 12'h400);
    @(posedge ref_clk_i);
    addr_i  <= `VSC_ADDR_MODE;
    wdata_i <= 12'h000;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    addr_i  <= `VSC_ADDR_IRQ_STAT;
    wdata_i <= 12'h003;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    #1;
    chk_active(12'h07F, 12'h3D9, 12'h400, 12'h400, 12'h05A, 12'h100);
    chk("lin_mode", 12'h000, vsc_word_t'(act_mode_o));
    rd_chk("irq_set_wins", `VSC_ADDR_IRQ_STAT, 12'h001);
  endtask : test_linear
  initial begin
    ref_clk_i = 1'b0;
    rst_b_i   = 1'b0;
    addr_i    = '0;
    wdata_i   = '0;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    err_total = 0;
    samples_checked = 0;
    cyc       = 0;
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    test_reset_values();
    test_staged_update();
    test_modes();
    test_irq();
    test_linear();
    results();
  end
endmodule : tb_video_scaler_control_regs
`default_nettype wire
